// *** core/rfb_reset_fanout.sv ***
// Reset fan-out, retained register files and boot source selection
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Main power-on resets all modules and pin, not battery domain.
// - Battery power-on resets only clock and battery register file.
// - Pin, watchdog, stop error, software, lockup, debug-port reset most, spare clock, timers.
// - System resets spare the power controller except three voltage fields.
// - Non power-on mode-controller reset keeps power-mode control and status.
// - Wakeup reset hits power fields, integration, id registers, memory and others only.
// - Wakeup reset drives pin only when pin caused the wake.
// - Deep-stop wakeup spares flash, cache and memory controller.
// - Deep-stop exit keeps id, repair, flash config and unique id registers.
// - Debug reset hits integration, mode, wakeup, others and pin.
// - System register file retained; cleared only by main power-on.
// - Battery register file cleared only by battery power-on.
// - Blank flash boots from ROM base; otherwise flash base.
// - ROM boot means bootloader mode.
// - Option register bits are read-only, loaded from option byte.
// - Boot core from option record; primary core default.
module rfb_reset_fanout (
   // Clock, main power-on and battery power-on
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        bat_por_b_in,
   // Reset sources (asynchronous levels, active high)
   input  wire logic        pin_rst_in,
   input  wire logic        wdog_rst_in,
   input  wire logic        stop_ack_error_in,
   input  wire logic        lockup_in,
   input  wire logic        dap_sys_rst_in,
   input  wire logic        debug_rst_in,
   input  wire logic        wake_rst_in,
   input  wire logic        wake_by_pin_in,
   input  wire logic        wake_from_deep_in,
   // Flash information
   input  wire logic        flash_blank_in,
   input  wire logic        opt_valid_in,
   input  wire logic [7:0]  opt_byte_in,
   // Register bus
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Per-domain resets, active low; reset pin drive active high
   output logic             pwr_ctrl_rst_b_out,
   output logic             pwr_fields_rst_b_out,
   output logic             sys_int_rst_b_out,
   output logic             sys_int_id_rst_b_out,
   output logic             mode_ctrl_rst_b_out,
   output logic             mode_regs_rst_b_out,
   output logic             wake_unit_rst_b_out,
   output logic             lp_timer_rst_b_out,
   output logic             rtc_rst_b_out,
   output logic             others_rst_b_out,
   output logic             mem_rst_b_out,
   output logic             pin_drive_out,
   // Boot
   output logic             boot_rom_out,
   output logic             bootloader_mode_out,
   output logic             boot_core_sec_out,
   output logic      [31:0] vec_base_out,
   output logic      [7:0]  flash_option_out
);
   // ===========================================
   // Source synchronisation
   // ===========================================
   localparam int unsigned NSRC = 9;
   logic [NSRC-1:0] src_raw;
   logic [NSRC-1:0] s1_q;
   logic [NSRC-1:0] s2_q;
   logic [NSRC-1:0] s1_d;

   assign src_raw = {wake_from_deep_in, wake_by_pin_in, wake_rst_in, debug_rst_in,
                     dap_sys_rst_in, lockup_in, stop_ack_error_in, wdog_rst_in, pin_rst_in};

   always_comb begin
      s1_d = src_raw;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s1_q;
      end
   end

   logic pin_s, wdog_s, sack_s, lock_s, dap_s, dbg_s, wake_s, wpin_s, deep_s;
   assign {deep_s, wpin_s, wake_s, dbg_s, dap_s, lock_s, sack_s, wdog_s, pin_s} = s2_q;

   // ===========================================
   // Register bus and software reset
   // ===========================================
   logic                    sw_rst_q, sw_rst_d;
   logic [rfb_pkg::REGFILE_AW-1:0] idx_q, idx_d;
   logic [31:0]             rdata_q, rdata_d;

   // Source groups
   logic sys_grp;
   logic dbg_grp;
   logic wake_grp;
   assign sys_grp  = pin_s | wdog_s | sack_s | sw_rst_q | lock_s | dap_s;
   assign dbg_grp  = dbg_s;
   assign wake_grp = wake_s;

   // ===========================================
   // Reset requests per domain
   // ===========================================
   logic rq_pwr, rq_pwrf, rq_sim, rq_simid, rq_mode, rq_modereg, rq_wake, rq_mem, rq_oth;
   always_comb begin
      rq_pwr     = 1'b0;
      rq_pwrf    = sys_grp | wake_grp;
      rq_sim     = sys_grp | dbg_grp | wake_grp;
      rq_simid   = sys_grp | dbg_grp | (wake_grp & ~deep_s);
      rq_mode    = sys_grp | dbg_grp;
      rq_modereg = 1'b0;
      rq_wake    = sys_grp | dbg_grp;
      rq_oth     = sys_grp | dbg_grp | wake_grp;
      rq_mem     = sys_grp | dbg_grp | (wake_grp & ~deep_s);
   end

   // Main power-on resets all except battery domain; lines below combine it
   logic [8:0] req_b;
   assign req_b = {~rq_mem, ~rq_oth, ~rq_wake, ~rq_modereg, ~rq_mode,
                   ~rq_simid, ~rq_sim, ~rq_pwrf, ~rq_pwr};

   logic [8:0] dom_b;
   genvar g;
   for (g = 0; g < 9; g++) begin : g_sync
      logic comb_b;
      assign comb_b = rst_b_in & req_b[g];
      rfb_rst_sync u_sync (
         .clk_in    (clk_in),
         .req_b_in  (comb_b),
         .rst_b_out (dom_b[g])
      );
   end

   // Timers and clock: main and battery power-on respectively
   logic tmr_b, rtc_b;
   rfb_rst_sync u_tmr (
      .clk_in    (clk_in),
      .req_b_in  (rst_b_in),
      .rst_b_out (tmr_b)
   );
   rfb_rst_sync u_rtc (
      .clk_in    (clk_in),
      .req_b_in  (bat_por_b_in),
      .rst_b_out (rtc_b)
   );

   assign pwr_ctrl_rst_b_out   = dom_b[0];
   assign pwr_fields_rst_b_out = dom_b[1];
   assign sys_int_rst_b_out    = dom_b[2];
   assign sys_int_id_rst_b_out = dom_b[3];
   assign mode_ctrl_rst_b_out  = dom_b[4];
   assign mode_regs_rst_b_out  = dom_b[5];
   assign wake_unit_rst_b_out  = dom_b[6];
   assign others_rst_b_out     = dom_b[7];
   assign mem_rst_b_out        = dom_b[8];
   assign lp_timer_rst_b_out   = tmr_b;
   assign rtc_rst_b_out        = rtc_b;

   // ===========================================
   // Reset pin drive
   // ===========================================
   logic pin_q, pin_d;
   always_comb begin
      pin_d = sys_grp | dbg_grp | (wake_grp & wpin_s);
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= pin_d;
      end
   end
   assign pin_drive_out = pin_q;

   // ===========================================
   // Cause record, sticky until written one or main power-on
   // ===========================================
   logic [rfb_pkg::CAUSE_W-1:0] cause_q, cause_d, cause_set;
   always_comb begin
      cause_set = '0;
      cause_set[rfb_pkg::C_PIN]      = pin_s;
      cause_set[rfb_pkg::C_WDOG]     = wdog_s;
      cause_set[rfb_pkg::C_SACK]     = sack_s;
      cause_set[rfb_pkg::C_SW]       = sw_rst_q;
      cause_set[rfb_pkg::C_LOCKUP]   = lock_s;
      cause_set[rfb_pkg::C_DAP]      = dap_s;
      cause_set[rfb_pkg::C_DEBUG]    = dbg_s;
      cause_set[rfb_pkg::C_WAKE]     = wake_s;
      cause_set[rfb_pkg::C_WAKEPIN]  = wake_s & wpin_s;
      cause_set[rfb_pkg::C_DEEPWAKE] = wake_s & deep_s;
      cause_d = cause_q;
      if (reg_wr_in && reg_addr_in == rfb_pkg::ADDR_CAUSE) begin
         cause_d = cause_q & ~reg_wdata_in[rfb_pkg::CAUSE_W-1:0];
      end
      // Set wins over a clear in the same cycle
      cause_d = cause_d | cause_set;
   end

   // ===========================================
   // Register files
   // ===========================================
   logic [7:0] sysrf_q [rfb_pkg::REGFILE_BYTES];
   logic [7:0] sysrf_d [rfb_pkg::REGFILE_BYTES];
   logic [7:0] batrf_q [rfb_pkg::REGFILE_BYTES];
   logic [7:0] batrf_d [rfb_pkg::REGFILE_BYTES];

   always_comb begin
      sysrf_d = sysrf_q;
      batrf_d = batrf_q;
      idx_d   = idx_q;
      sw_rst_d = 1'b0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            rfb_pkg::ADDR_SYSRF: sysrf_d[idx_q] = reg_wdata_in[7:0];
            rfb_pkg::ADDR_BATRF: batrf_d[idx_q] = reg_wdata_in[7:0];
            rfb_pkg::ADDR_RFIDX: idx_d = reg_wdata_in[rfb_pkg::REGFILE_AW-1:0];
            rfb_pkg::ADDR_SWRST: sw_rst_d = reg_wdata_in[0];
            default: ;
         endcase
      end
   end

   // Retained through every reset but main power-on
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < rfb_pkg::REGFILE_BYTES; i++) begin
            sysrf_q[i] <= 8'h00;
         end
         idx_q   <= '0;
         cause_q <= rfb_pkg::CAUSE_W'(1);
      end else begin
         sysrf_q <= sysrf_d;
         idx_q   <= idx_d;
         cause_q <= cause_d;
      end
   end

   // One-cycle pulse; not cleared by its own domain reset, so pin and cause still see it
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sw_rst_q <= 1'b0;
      end else begin
         sw_rst_q <= sw_rst_d;
      end
   end

   // Battery domain: only its own power-on clears it
   always_ff @(posedge clk_in or negedge rtc_b) begin
      if (!rtc_b) begin
         for (int i = 0; i < rfb_pkg::REGFILE_BYTES; i++) begin
            batrf_q[i] <= 8'h00;
         end
      end else begin
         batrf_q <= batrf_d;
      end
   end

   // ===========================================
   // Boot selection
   // ===========================================
   rfb_pkg::rfb_boot_e st_q, st_d;
   logic       blank_s1_q, blank_s2_q, ov_s1_q, ov_s2_q;
   logic [7:0] opt_q, opt_d;
   logic       rom_q, rom_d, core_q, core_d;
   logic [31:0] vec_q, vec_d;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         blank_s1_q <= 1'b0;
         blank_s2_q <= 1'b0;
         ov_s1_q    <= 1'b0;
         ov_s2_q    <= 1'b0;
      end else begin
         blank_s1_q <= flash_blank_in;
         blank_s2_q <= blank_s1_q;
         ov_s1_q    <= opt_valid_in;
         ov_s2_q    <= ov_s1_q;
      end
   end

   always_comb begin
      st_d  = st_q;
      opt_d = opt_q;
      rom_d = rom_q;
      core_d = core_q;
      vec_d = vec_q;
      case (st_q)
         rfb_pkg::RFB_BOOT_IDLE: st_d = rfb_pkg::RFB_BOOT_LOAD;
         rfb_pkg::RFB_BOOT_LOAD: begin
            // Option byte is stable once valid rises
            if (ov_s2_q) begin
               opt_d = opt_byte_in;
               rom_d = blank_s2_q;
               core_d = ~opt_byte_in[rfb_pkg::OPT_BOOT_CORE_B];
               vec_d = blank_s2_q ? rfb_pkg::ROM_VEC_BASE
                                  : rfb_pkg::FLASH_VEC_BASE;
               st_d  = rfb_pkg::RFB_BOOT_DONE;
            end
         end
         rfb_pkg::RFB_BOOT_DONE: st_d = rfb_pkg::RFB_BOOT_DONE;
         default: st_d = rfb_pkg::RFB_BOOT_IDLE;
      endcase
   end

   // Boot decision is taken again after any reset of the integration unit
   always_ff @(posedge clk_in or negedge sys_int_rst_b_out) begin
      if (!sys_int_rst_b_out) begin
         st_q  <= rfb_pkg::RFB_BOOT_IDLE;
         opt_q <= rfb_pkg::OPT_RESET_VAL;
         rom_q <= 1'b0;
         core_q <= 1'b0;
         vec_q <= rfb_pkg::FLASH_VEC_BASE;
      end else begin
         st_q  <= st_d;
         opt_q <= opt_d;
         rom_q <= rom_d;
         core_q <= core_d;
         vec_q <= vec_d;
      end
   end

   assign flash_option_out    = opt_q;
   assign boot_rom_out        = rom_q;
   assign bootloader_mode_out = rom_q;
   // Erased bit reads one: primary core default
   assign boot_core_sec_out   = core_q;
   assign vec_base_out        = vec_q;

   // ===========================================
   // Read data
   // ===========================================
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (reg_rd_in) begin
         case (reg_addr_in)
            rfb_pkg::ADDR_STATUS: rdata_d = {27'h0, boot_core_sec_out, rom_q, st_q, 1'b0};
            rfb_pkg::ADDR_OPTION: rdata_d = {24'h0, opt_q};
            rfb_pkg::ADDR_CAUSE:  rdata_d = {21'h0, cause_q};
            rfb_pkg::ADDR_SYSRF:  rdata_d = {24'h0, sysrf_q[idx_q]};
            rfb_pkg::ADDR_BATRF:  rdata_d = {24'h0, batrf_q[idx_q]};
            rfb_pkg::ADDR_RFIDX:  rdata_d = {27'h0, idx_q};
            default:              rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata_out = rdata_q;
endmodule

// *** shared/rfb_pkg.sv ***
// Package for the reset fan-out and boot select block
package rfb_pkg;
   // Reset synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;
   // Register files: 32 bytes each
   localparam int unsigned REGFILE_BYTES = 32;
   localparam int unsigned REGFILE_AW    = 5;
   // Option byte field positions
   localparam int unsigned OPT_W           = 8;
   localparam int unsigned OPT_BOOT_CORE_B = 0;
   localparam int unsigned OPT_BOOT_SRC_B  = 1;
   localparam logic [7:0]  OPT_RESET_VAL   = 8'hFF;
   // Option record index for boot core selection
   localparam logic [7:0]  BOOT_CORE_REC_IDX = 8'h84;
   // Vector table bases (plain defaults)
   localparam logic [31:0] ROM_VEC_BASE   = 32'h1000_0000;
   localparam logic [31:0] FLASH_VEC_BASE = 32'h0000_0000;
   // Register bus offsets
   localparam logic [3:0] ADDR_STATUS   = 4'h0;
   localparam logic [3:0] ADDR_OPTION   = 4'h1;
   localparam logic [3:0] ADDR_CAUSE    = 4'h2;
   localparam logic [3:0] ADDR_SWRST    = 4'h3;
   localparam logic [3:0] ADDR_SYSRF    = 4'h8;
   localparam logic [3:0] ADDR_BATRF    = 4'h9;
   localparam logic [3:0] ADDR_RFIDX    = 4'hA;
   // Cause register bit positions
   localparam int unsigned CAUSE_W    = 11;
   localparam int unsigned C_POR      = 0;
   localparam int unsigned C_PIN      = 1;
   localparam int unsigned C_WDOG     = 2;
   localparam int unsigned C_SACK     = 3;
   localparam int unsigned C_SW       = 4;
   localparam int unsigned C_LOCKUP   = 5;
   localparam int unsigned C_DAP      = 6;
   localparam int unsigned C_DEBUG    = 7;
   localparam int unsigned C_WAKE     = 8;
   localparam int unsigned C_WAKEPIN  = 9;
   localparam int unsigned C_DEEPWAKE = 10;
   // Boot state machine
   typedef enum logic [1:0] {
      RFB_BOOT_IDLE  = 2'b00,
      RFB_BOOT_LOAD  = 2'b01,
      RFB_BOOT_DONE  = 2'b10
   } rfb_boot_e;
endpackage

// *** core/rfb_rst_sync.sv ***
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/10ps
module rfb_rst_sync (
   // Clock and reset request
   input  wire logic clk_in,
   input  wire logic req_b_in,
   // Synchronised reset
   output logic      rst_b_out
);
   logic [rfb_pkg::SYNC_STAGES-1:0] stage_q;
   logic [rfb_pkg::SYNC_STAGES-1:0] stage_d;

   always_comb begin
      stage_d = {stage_q[rfb_pkg::SYNC_STAGES-2:0], 1'b1};
   end

   // Each domain leaves reset on the SYNC_STAGES-th edge after its request is removed
   always_ff @(posedge clk_in or negedge req_b_in) begin
      if (!req_b_in) begin
         stage_q <= '0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign rst_b_out = stage_q[rfb_pkg::SYNC_STAGES-1];
endmodule

// *** verif/rfb_reset_fanout_props.sv ***
// Checker for the reset fan-out and boot select block
`timescale 1ns/10ps
module rfb_reset_fanout_props (
   // Clock, reset and sources
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        pin_rst_in,
   input wire logic        wdog_rst_in,
   input wire logic        stop_ack_error_in,
   input wire logic        lockup_in,
   input wire logic        dap_sys_rst_in,
   input wire logic        debug_rst_in,
   input wire logic        wake_rst_in,
   input wire logic        wake_by_pin_in,
   input wire logic        wake_from_deep_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   // Observed outputs
   input wire logic [31:0] reg_rdata_out,
   input wire logic        pwr_ctrl_rst_b_out,
   input wire logic        sys_int_rst_b_out,
   input wire logic        sys_int_id_rst_b_out,
   input wire logic        mode_ctrl_rst_b_out,
   input wire logic        mode_regs_rst_b_out,
   input wire logic        wake_unit_rst_b_out,
   input wire logic        lp_timer_rst_b_out,
   input wire logic        others_rst_b_out,
   input wire logic        mem_rst_b_out,
   input wire logic        pin_drive_out,
   input wire logic        boot_rom_out,
   input wire logic        bootloader_mode_out,
   input wire logic [31:0] vec_base_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [2:0] up_q;
   logic [2:0] up_d;
   logic       hard;
   logic       calm;
   // ==========================================================
   // Settle window after power-on, saturating
   always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) up_q <= 3'h0;
      else up_q <= up_d;
   end
   assign hard = pin_rst_in | wdog_rst_in | stop_ack_error_in | lockup_in | dap_sys_rst_in | debug_rst_in;
   // Writes may start a software reset, so they break the quiet window
   assign calm = (up_q == 3'h7) & ~hard & ~reg_wr_in;
   // ==========================================================
   // Properties
   a_pwr_kept: assert property (up_q == 3'h7 |-> pwr_ctrl_rst_b_out && mode_regs_rst_b_out && lp_timer_rst_b_out)
      else $error("power, mode register or timer reset outside power-on");
   a_wake_spares_mode: assert property (calm [*8] |-> mode_ctrl_rst_b_out && wake_unit_rst_b_out)
      else $error("wake reset hit mode controller or wakeup unit");
   a_wake_pin_quiet: assert property ((calm && !(wake_rst_in && wake_by_pin_in)) [*8] |-> !pin_drive_out)
      else $error("reset pin driven without cause");
   a_deep_mem_kept: assert property ((calm && !(wake_rst_in && !wake_from_deep_in)) [*8] |->
      mem_rst_b_out && sys_int_id_rst_b_out)
      else $error("memory or id registers reset on deep wake");
   a_src_asserts: assert property ($rose(hard) |-> ##[1:4] (!sys_int_rst_b_out && !mode_ctrl_rst_b_out && !wake_unit_rst_b_out))
      else $error("system source did not reset its domains");
   a_pin_follows: assert property ($rose(hard) |-> ##[1:6] pin_drive_out)
      else $error("reset pin not driven for system source");
   a_wake_hits_sys: assert property ($rose(wake_rst_in) |-> ##[1:4] (!sys_int_rst_b_out && !others_rst_b_out))
      else $error("wake reset missed integration unit or others");
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data present without a read");
   a_boot_vec: assert property (up_q == 3'h7 |-> bootloader_mode_out == boot_rom_out &&
      vec_base_out == (boot_rom_out ? rfb_pkg::ROM_VEC_BASE : rfb_pkg::FLASH_VEC_BASE))
      else $error("vector base or loader mode disagrees with boot source");
endmodule

bind rfb_reset_fanout rfb_reset_fanout_props i_props (.*);

// *** verif/rfb_flash_info_model.sv ***
// Flash information space model that loads the option byte after reset
`timescale 1ns/10ps
module rfb_flash_info_model #(
   parameter int unsigned LOAD_CYC = 5
) (
   // Clock and integration-unit reset
   input  wire logic       clk_in,
   input  wire logic       sys_int_rst_b_in,
   // Programmed option byte
   input  wire logic [7:0] opt_prog_in,
   // Toward the block
   output logic            opt_valid_out,
   output logic [7:0]      opt_byte_out
);
   logic [3:0] cnt_q = 4'h0;
   logic [3:0] cnt_d;
   logic [7:0] byte_q = 8'h5A;
   logic [7:0] byte_d;
   // Until loaded the lines toggle, so a stale byte is never taken for data
   always_comb begin
      cnt_d = sys_int_rst_b_in ? ((cnt_q == 4'(LOAD_CYC)) ? cnt_q : cnt_q + 4'h1) : 4'h0;
      byte_d = (cnt_d == 4'(LOAD_CYC)) ? opt_prog_in : ~byte_q;
   end
   always_ff @(posedge clk_in) begin
      cnt_q <= cnt_d;
      byte_q <= byte_d;
   end
   assign opt_valid_out = (cnt_q == 4'(LOAD_CYC));
   assign opt_byte_out = byte_q;
endmodule

// *** verif/test_reset_fanout_and_boot_select.sv ***
// Self-checking bench for the reset fan-out and boot select block
`timescale 1ns/10ps
module test_reset_fanout_and_boot_select;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        bat_por_b_in = 1'b0;
   logic [5:0]  src = 6'h00;
   logic        wake_rst = 1'b0;
   logic        wake_pin = 1'b0;
   logic        wake_deep = 1'b0;
   logic        blank = 1'b0;
   logic [7:0]  opt = 8'hFF;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rv;
   logic [7:0]  d1;
   logic [7:0]  d2;
   logic [4:0]  idx;
   wire         opt_valid;
   wire [7:0]   opt_byte;
   wire [31:0]  rdata;
   wire [10:0]  rst_v;
   wire         pin_drive;
   wire         boot_rom;
   wire         boot_ldr;
   wire         core_sec;
   wire [31:0]  vec;
   wire [7:0]   flash_option_register;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc = 0;

   always #2 clk_in = ~clk_in;

   // Source order in src: debug, dap, lockup, stop error, watchdog, pin
   rfb_reset_fanout i_dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .bat_por_b_in(bat_por_b_in),
      .pin_rst_in(src[0]), .wdog_rst_in(src[1]), .stop_ack_error_in(src[2]), .lockup_in(src[3]),
      .dap_sys_rst_in(src[4]), .debug_rst_in(src[5]), .wake_rst_in(wake_rst),
      .wake_by_pin_in(wake_pin), .wake_from_deep_in(wake_deep),
      .flash_blank_in(blank), .opt_valid_in(opt_valid), .opt_byte_in(opt_byte),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .pwr_ctrl_rst_b_out(rst_v[10]), .pwr_fields_rst_b_out(rst_v[9]), .sys_int_rst_b_out(rst_v[8]),
      .sys_int_id_rst_b_out(rst_v[7]), .mode_ctrl_rst_b_out(rst_v[6]), .mode_regs_rst_b_out(rst_v[5]),
      .wake_unit_rst_b_out(rst_v[4]), .lp_timer_rst_b_out(rst_v[3]), .rtc_rst_b_out(rst_v[2]),
      .others_rst_b_out(rst_v[1]), .mem_rst_b_out(rst_v[0]), .pin_drive_out(pin_drive),
      .boot_rom_out(boot_rom), .bootloader_mode_out(boot_ldr), .boot_core_sec_out(core_sec),
      .vec_base_out(vec), .flash_option_out(flash_option_register));

   rfb_flash_info_model i_flash (.clk_in(clk_in), .sys_int_rst_b_in(rst_v[8]), .opt_prog_in(opt),
      .opt_valid_out(opt_valid), .opt_byte_out(opt_byte));

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk_in);
      #1 chk(rdata, 32'h0);
   endtask

   task automatic rf_chk(input logic [7:0] a, input logic [7:0] b);
      bus_wr(rfb_pkg::ADDR_RFIDX, {27'h0, idx});
      bus_rd(rfb_pkg::ADDR_SYSRF, rv);
      chk(rv[7:0], a);
      bus_rd(rfb_pkg::ADDR_BATRF, rv);
      chk(rv[7:0], b);
   endtask

   task automatic boot_chk();
      chk(boot_rom, blank);
      chk(boot_ldr, blank);
      chk(vec, blank ? rfb_pkg::ROM_VEC_BASE : rfb_pkg::FLASH_VEC_BASE);
      chk(flash_option_register, opt);
      chk(core_sec, {31'h0, ~opt[0]});
   endtask

   // Expected {pin drive, domains seen in reset}; kinds 0-4 system, 5 debug, 6 software, 7 wake
   function automatic logic [11:0] exp_low(input int k, input logic bp, input logic dp);
      if (k == 7) return {bp, 3'b011, ~dp, 5'b00000, 1'b1, ~dp};
      if (k == 5) return {1'b1, 11'b00111010011};
      return {1'b1, 11'b01111010011};
   endfunction

   task automatic hit(input int k, input logic bp, input logic dp, input int len);
      logic [11:0] seen;
      seen = 12'h0;
      for (int i = 0; i < len + 10; i++) begin
         @(posedge clk_in);
         if (i == 0 && k < 6) src <= 6'h01 << k;
         if (i == 0 && k == 6) begin
            wr <= 1'b1;
            addr <= rfb_pkg::ADDR_SWRST;
            wdata <= 32'h1;
         end
         if (i == 0 && k == 7) begin
            wake_rst <= 1'b1;
            wake_pin <= bp;
            wake_deep <= dp;
         end
         if (i == 1) wr <= 1'b0;
         if (i == len) begin
            src <= 6'h00;
            wake_rst <= 1'b0;
         end
         #1 seen = seen | {pin_drive, ~rst_v};
      end
      chk(seen, exp_low(k, bp, dp));
   endtask

   // ==========================================================
   // Main sequence
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      rv = $urandom(32'h8d2e9de3);
      repeat (4) @(posedge clk_in);
      bat_por_b_in <= 1'b1;
      opt <= rv[7:0];
      blank <= rv[8];
      repeat (7) @(posedge clk_in);
      #1 chk({pin_drive, rst_v}, 12'h804);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      #1 chk({pin_drive, rst_v}, 12'h7FF);
      boot_chk();
      // Status: core select, boot source, load finished
      bus_rd(rfb_pkg::ADDR_STATUS, rv);
      chk(rv, {27'h0, ~opt[0], blank, 3'b100});
      bus_rd(rfb_pkg::ADDR_OPTION, rv);
      chk(rv, {24'h0, opt});
      bus_wr(rfb_pkg::ADDR_OPTION, {24'h0, ~opt});
      bus_rd(rfb_pkg::ADDR_OPTION, rv);
      chk(rv, {24'h0, opt});
      bus_rd(4'h5, rv);
      chk(rv, 32'h0);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      idx = 5'($urandom);
      bus_wr(rfb_pkg::ADDR_RFIDX, {27'h0, idx});
      bus_wr(rfb_pkg::ADDR_SYSRF, {24'h0, d1});
      bus_wr(rfb_pkg::ADDR_BATRF, {24'h0, d2});
      for (int k = 0; k < 7; k++) hit(k, 1'b0, 1'b0, 3 + $urandom % 4);
      for (int w = 0; w < 4; w++) hit(7, w[0], w[1], 3 + $urandom % 4);
      wake_pin <= 1'b0;
      wake_deep <= 1'b0;
      // Every cause has been seen at least once; write one to clear
      bus_rd(rfb_pkg::ADDR_CAUSE, rv);
      chk(rv, 32'h0000_07FF);
      bus_wr(rfb_pkg::ADDR_CAUSE, 32'h0000_07FF);
      bus_rd(rfb_pkg::ADDR_CAUSE, rv);
      chk(rv, 32'h0000_0000);
      rf_chk(d1, d2);
      boot_chk();
      // Power-on in mid-run: system file cleared, battery file kept
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 chk(rst_v[2], 1'b1);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      rf_chk(8'h00, d2);
      @(posedge clk_in);
      bat_por_b_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 chk({pin_drive, rst_v}, 12'h7FB);
      @(posedge clk_in);
      bat_por_b_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rf_chk(8'h00, 8'h00);
      conclude();
   end
endmodule
